//--- core/dcbist_defines.svh
// Offsets, field positions, reset values and counts of the cache self-test engine
`ifndef DCBIST_DEFINES_SVH
`define DCBIST_DEFINES_SVH

// Diagnose register indexes on the register port
`define DCB_IDX_CFG      5'h00
`define DCB_IDX_TAG_WR   5'h01
`define DCB_IDX_DW_WR    5'h02
`define DCB_IDX_DWP_WR   5'h06
`define DCB_IDX_TAG_RB   5'h0a
`define DCB_IDX_DW_RB    5'h0c
`define DCB_IDX_DWP_RB   5'h10
`define DCB_IDX_LAST     5'h13

// Configuration register bit positions
`define DCB_BIT_TEST     20
`define DCB_BIT_SELFTEST 19
`define DCB_BIT_SSTEP    18
`define DCB_BIT_DREAD    17
`define DCB_BIT_FWD      16
`define DCB_BIT_FULL     15
`define DCB_ADDR_MSB     14
`define DCB_ADDR_LSB     3

// Widths and polynomials
`define DCB_ADDR_W       12
`define DCB_TAG_W        23
`define DCB_DW_W         66
`define DCB_ADDR_TAPS    12'h84c
`define DCB_TAG_TAPS     23'h400010
`define DCB_DW_TAPS      66'h2_0000_0000_0000_0301

// Entries stepped by one full sweep: every non-zero address once
`define DCB_SWEEP_STEPS  4095
`define DCB_CFG_RESET    32'h0000_0000
`define DCB_ADDR_RESET   12'h001

`endif

//--- core/dcbist_pkg.sv
// Types shared by the cache self-test engine
package dcbist_pkg;
   typedef enum logic [2:0] {
      DCB_IDLE, DCB_READ1, DCB_WRITE, DCB_READ2, DCB_DREAD, DCB_DWRITE
   } dcbist_state_t;
endpackage

//--- core/dcbist_step_if.sv
// Control and data of one shift-register unit (address LFSR or signature)
`timescale 1ns/1ns
interface dcbist_step_if #(parameter int W = 12);
   logic         load;
   logic         step;
   logic         clr;
   logic         mode;
   logic [W-1:0] din;
   logic [W-1:0] q;
   logic [W-1:0] nq;
   modport ctl  (output load, step, clr, mode, din, input q, nq);
   modport unit (input load, step, clr, mode, din, output q, nq);
endinterface

//--- core/dcbist_lfsr.sv
// Address LFSR with forward and exactly inverse reverse step
`timescale 1ns/1ns
module dcbist_lfsr
   import dcbist_pkg::*;
#(
   parameter int             W     = 12,
   parameter logic [W-1:0]   TAPS  = 12'h84c,
   parameter logic [W-1:0]   RESET = 12'h001
) (
   input  wire logic clk_in,
   input  wire logic resetn_in,
   dcbist_step_if.unit u
);
   logic [W-1:0] fwd;
   logic [W-1:0] rev;
   initial begin
      if (W < 2 || !TAPS[W-1]) $error("dcbist_lfsr: bad width or taps");
   end

   // Reverse feedback recovers the bit that the forward step shifted out
   assign fwd  = {u.q[W-2:0], ^(u.q & TAPS)};
   assign rev  = {u.q[0] ^ (^(u.q[W-1:1] & TAPS[W-2:0])), u.q[W-1:1]};
   assign u.nq = u.clr ? RESET : u.load ? u.din :
                 u.step ? (u.mode ? fwd : rev) : u.q;

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         u.q <= RESET;
      end else begin
         u.q <= u.nq;
      end
   end
endmodule

//--- core/dcbist_misr.sv
// Read-back register that loads read data or compresses it into a signature
`timescale 1ns/1ns
module dcbist_misr
   import dcbist_pkg::*;
#(
   parameter int           W    = 23,
   parameter logic [W-1:0] TAPS = 23'h400010
) (
   input  wire logic clk_in,
   input  wire logic resetn_in,
   dcbist_step_if.unit u
);
   initial begin
      if (W < 2 || !TAPS[W-1]) $error("dcbist_misr: bad width or taps");
   end

   // Capture wins over a clear arriving in the same cycle
   assign u.nq = u.load ? u.din :
                 u.step ? ({u.q[W-2:0], ^(u.q & TAPS)} ^ u.din) :
                 u.clr  ? '0 : u.q;

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         u.q <= '0;
      end else begin
         u.q <= u.nq;
      end
   end
endmodule

//--- core/dcbist_engine.sv
// Self-test and diagnose engine of the two-way L1 data cache
//
// Notes on behaviour
// - Diagnose reads or writes any single tag, dirty or data entry.
// - Test mode disables normal cache accesses; only this engine uses arrays.
// - Self-test select set starts self-test; clear starts diagnose access.
// - Single step tests one entry and advances LFSR; else sweep all.
// - Diagnose read bit picks read or write; ignored under self-test.
// - Direction bit set steps LFSR forward, clear steps it in reverse.
// - Address field 12 bits: 10 for tag/dirty, 11 for data, last for group.
// - Bit 27 picks doubleword pair or whole group per full-line bit.
// - In self-test the address field runs as a 12-bit LFSR.
// - Data arrays' eleventh address bits equal, or complementary if full-line.
// - Forward polynomial x12+x7+x4+x3+1; reverse uses its reciprocal.
// - Write-only registers supply tag, dirty and data write values.
// - Diagnose writes one tag group; self-test writes both; even parity.
// - Write words 0 and 2 routed by bit 27 through the left array.
// - Write words 1 and 3 routed by bit 27 xor full-line, right array.
// - Each parity register holds two even parity bits per doubleword.
// - Read-back registers take read data or signatures; any write to them clears all, except in a capture or signature step cycle.
// - Tag read-back compresses 23 bits with x23+x5+1 in self-test.
// - Data read-back compresses 64 data plus 2 parity, x66+x10+x9+x+1.
// - Tag read-back 0 and 1 return group 0 and group 1 bits.
// - Data read-back words map to left/right upper/lower array halves.
// - Diagnose instruction in test mode starts self-test, or diagnose read or write.
// - Self-test: 3 cycles single step, full sweep longer; sync stalls.
// - Self-test writes only when LFSR last bit set; tag also bit 27.
`timescale 1ns/1ns
`include "dcbist_defines.svh"
module dcbist_engine
   import dcbist_pkg::*;
#(
   parameter int SWEEP_STEPS = `DCB_SWEEP_STEPS
) (
   input  wire logic                  clk_in,
   input  wire logic                  resetn_in,
   // Diagnose register port
   input  wire logic                  reg_wr_in,
   input  wire logic                  reg_rd_in,
   input  wire logic [4:0]            reg_sel_in,
   input  wire logic [63:0]           reg_wdata_in,
   output logic      [63:0]           reg_rdata_out,
   // Pipeline side
   input  wire logic                  diag_issue_in,
   output logic                       busy_out,
   output logic                       cache_disable_out,
   // Tag and dirty array
   output logic      [9:0]            tag_addr_out,
   output logic      [1:0]            tag_we_out,
   output logic      [`DCB_TAG_W-1:0] tag_wdata_out,
   input  wire logic [`DCB_TAG_W-1:0] tag_rdata0_in,
   input  wire logic [`DCB_TAG_W-1:0] tag_rdata1_in,
   // Left and right data arrays, upper and lower halves
   output logic      [10:0]           left_addr_out,
   output logic      [10:0]           right_addr_out,
   output logic                       data_we_out,
   output logic      [`DCB_DW_W-1:0]  left_upper_wdata_out,
   output logic      [`DCB_DW_W-1:0]  right_upper_wdata_out,
   output logic      [`DCB_DW_W-1:0]  left_lower_wdata_out,
   output logic      [`DCB_DW_W-1:0]  right_lower_wdata_out,
   input  wire logic [`DCB_DW_W-1:0]  left_upper_rdata_in,
   input  wire logic [`DCB_DW_W-1:0]  right_upper_rdata_in,
   input  wire logic [`DCB_DW_W-1:0]  left_lower_rdata_in,
   input  wire logic [`DCB_DW_W-1:0]  right_lower_rdata_in
);
   localparam int AW = `DCB_ADDR_W;

   dcbist_state_t      state;
   dcbist_state_t      next_state;
   logic               cache_test_mode;
   logic               selftest_select;
   logic               single_step_select;
   logic               diag_read_select;
   logic               lfsr_forward_select;
   logic               full_line_select;
   logic [11:0]        step_count;
   logic [`DCB_TAG_W-1:0] tag_dirty_write_data;
   logic [`DCB_DW_W-1:0]  data_write [4];
   logic [`DCB_DW_W-1:0]  rb_din [4];
   logic               cfg_wr;
   logic               rb_clear;
   logic               sweep_done;
   logic [AW-1:0]      next_addr;

   dcbist_step_if #(.W(AW))         addr_if ();
   dcbist_step_if #(.W(`DCB_TAG_W)) tag_if [2] ();
   dcbist_step_if #(.W(`DCB_DW_W))  dw_if [4] ();

   initial begin
      if (SWEEP_STEPS < 1 || SWEEP_STEPS > 4095) begin
         $error("dcbist_engine: SWEEP_STEPS out of range");
      end
   end

   // Register index helpers used by the write decode and read-back clear only
   function automatic logic in_group(input logic [4:0] sel,
                                     input logic [4:0] base,
                                     input logic [4:0] cnt);
      in_group = (sel >= base) && (sel < base + cnt);
   endfunction

   function automatic logic [1:0] group_idx(input logic [4:0] sel,
                                            input logic [4:0] base);
      logic [4:0] d;
      d = sel - base;
      group_idx = d[1:0];
   endfunction

   // Data array index: ten common bits plus the per-array eleventh bit
   function automatic logic [10:0] data_index(input logic [AW-1:0] a,
                                              input logic flip);
      data_index = {a[AW-1:2], a[1] ^ flip};
   endfunction

   // Configuration is frozen while an operation runs
   assign cfg_wr = reg_wr_in && reg_sel_in == `DCB_IDX_CFG && state == DCB_IDLE;
   assign rb_clear = reg_wr_in && in_group(reg_sel_in, `DCB_IDX_TAG_RB, 5'd10);
   assign sweep_done = single_step_select ||
                       step_count == 12'(SWEEP_STEPS - 1);

   // Configuration register
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         cache_test_mode     <= 1'b0;
         selftest_select     <= 1'b0;
         single_step_select  <= 1'b0;
         diag_read_select    <= 1'b0;
         lfsr_forward_select <= 1'b0;
         full_line_select    <= 1'b0;
      end else if (cfg_wr) begin
         cache_test_mode     <= reg_wdata_in[`DCB_BIT_TEST];
         selftest_select     <= reg_wdata_in[`DCB_BIT_SELFTEST];
         single_step_select  <= reg_wdata_in[`DCB_BIT_SSTEP];
         diag_read_select    <= reg_wdata_in[`DCB_BIT_DREAD];
         lfsr_forward_select <= reg_wdata_in[`DCB_BIT_FWD];
         full_line_select    <= reg_wdata_in[`DCB_BIT_FULL];
      end
   end

   // Write-only data registers; parity writes touch only the top two bits
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         tag_dirty_write_data <= '0;
         for (int i = 0; i < 4; i++) begin
            data_write[i] <= '0;
         end
      end else if (reg_wr_in) begin
         if (reg_sel_in == `DCB_IDX_TAG_WR) begin
            tag_dirty_write_data <= reg_wdata_in[`DCB_TAG_W-1:0];
         end
         if (in_group(reg_sel_in, `DCB_IDX_DW_WR, 5'd4)) begin
            data_write[group_idx(reg_sel_in, `DCB_IDX_DW_WR)][63:0]
               <= reg_wdata_in;
         end
         if (in_group(reg_sel_in, `DCB_IDX_DWP_WR, 5'd4)) begin
            data_write[group_idx(reg_sel_in, `DCB_IDX_DWP_WR)][65:64]
               <= reg_wdata_in[1:0];
         end
      end
   end

   // Address LFSR: loaded by config writes, stepped after each entry
   assign addr_if.load = cfg_wr;
   assign addr_if.din  = reg_wdata_in[`DCB_ADDR_MSB:`DCB_ADDR_LSB];
   assign addr_if.step = state == DCB_READ2;
   assign addr_if.mode = lfsr_forward_select;
   assign addr_if.clr  = 1'b0;

   dcbist_lfsr #(
      .W     (AW),
      .TAPS  (`DCB_ADDR_TAPS),
      .RESET (`DCB_ADDR_RESET)
   ) u_addr (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .u         (addr_if.unit)
   );

   // Operation sequencer
   always_comb begin
      next_state = state;
      unique case (state)
         DCB_IDLE: begin
            if (diag_issue_in && cache_test_mode) begin
               if (selftest_select) begin
                  next_state = DCB_READ1;
               end else if (diag_read_select) begin
                  next_state = DCB_DREAD;
               end else begin
                  next_state = DCB_DWRITE;
               end
            end
         end
         DCB_READ1:  next_state = DCB_WRITE;
         DCB_WRITE:  next_state = DCB_READ2;
         DCB_READ2:  next_state = sweep_done ? DCB_IDLE : DCB_READ1;
         DCB_DREAD:  next_state = DCB_IDLE;
         DCB_DWRITE: next_state = DCB_IDLE;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         state <= DCB_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         step_count <= '0;
      end else if (state == DCB_IDLE) begin
         step_count <= '0;
      end else if (state == DCB_READ2) begin
         step_count <= step_count + 12'h001;
      end
   end

   // Pipeline status; a sync stalls while busy_out is high
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         busy_out          <= 1'b0;
         cache_disable_out <= 1'b0;
      end else begin
         busy_out          <= next_state != DCB_IDLE;
         cache_disable_out <= cfg_wr ? reg_wdata_in[`DCB_BIT_TEST]
                                     : cache_test_mode;
      end
   end

   // Array addresses follow the LFSR value the next cycle will hold
   assign next_addr = addr_if.nq;

   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         tag_addr_out   <= '0;
         left_addr_out  <= '0;
         right_addr_out <= '0;
      end else begin
         tag_addr_out   <= next_addr[AW-1:2];
         left_addr_out  <= data_index(next_addr, 1'b0);
         right_addr_out <= data_index(next_addr,
                              cfg_wr ? reg_wdata_in[`DCB_BIT_FULL]
                                     : full_line_select);
      end
   end

   // Write enables, with the self-test write mask from the address bits
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         tag_we_out  <= 2'b00;
         data_we_out <= 1'b0;
      end else begin
         tag_we_out  <= 2'b00;
         data_we_out <= 1'b0;
         if (next_state == DCB_WRITE) begin
            data_we_out <= addr_if.q[0];
            tag_we_out  <= {2{addr_if.q[0] & addr_if.q[1]}};
         end else if (next_state == DCB_DWRITE) begin
            data_we_out <= 1'b1;
            tag_we_out  <= addr_if.q[0] ? 2'b10 : 2'b01;
         end
      end
   end

   // Left array carries words 0 and 2, right array words 1 and 3
   assign tag_wdata_out         = tag_dirty_write_data;
   assign left_upper_wdata_out  = data_write[0];
   assign left_lower_wdata_out  = data_write[2];
   assign right_upper_wdata_out = data_write[1];
   assign right_lower_wdata_out = data_write[3];

   // Read-back and signature registers
   assign rb_din[0] = left_upper_rdata_in;
   assign rb_din[1] = right_upper_rdata_in;
   assign rb_din[2] = left_lower_rdata_in;
   assign rb_din[3] = right_lower_rdata_in;

   assign tag_if[0].din = tag_rdata0_in;
   assign tag_if[1].din = tag_rdata1_in;

   for (genvar g = 0; g < 2; g++) begin : g_tag
      assign tag_if[g].load = state == DCB_DREAD;
      assign tag_if[g].step = state == DCB_READ1 ||
                              state == DCB_READ2;
      assign tag_if[g].clr  = rb_clear;
      assign tag_if[g].mode = 1'b0;
      dcbist_misr #(
         .W    (`DCB_TAG_W),
         .TAPS (`DCB_TAG_TAPS)
      ) u_tag (
         .clk_in    (clk_in),
         .resetn_in (resetn_in),
         .u         (tag_if[g].unit)
      );
   end

   for (genvar g = 0; g < 4; g++) begin : g_dw
      assign dw_if[g].din  = rb_din[g];
      assign dw_if[g].load = state == DCB_DREAD;
      assign dw_if[g].step = state == DCB_READ1 ||
                             state == DCB_READ2;
      assign dw_if[g].clr  = rb_clear;
      assign dw_if[g].mode = 1'b0;
      dcbist_misr #(
         .W    (`DCB_DW_W),
         .TAPS (`DCB_DW_TAPS)
      ) u_dw (
         .clk_in    (clk_in),
         .resetn_in (resetn_in),
         .u         (dw_if[g].unit)
      );
   end

   // Register read port; write-only and unmapped indexes read as zero
   always_ff @(posedge clk_in) begin
      if (!resetn_in) begin
         reg_rdata_out <= '0;
      end else if (reg_rd_in) begin
         reg_rdata_out <= '0;
         if (reg_sel_in == `DCB_IDX_CFG) begin
            reg_rdata_out[`DCB_BIT_TEST]     <= cache_test_mode;
            reg_rdata_out[`DCB_BIT_SELFTEST] <= selftest_select;
            reg_rdata_out[`DCB_BIT_SSTEP]    <= single_step_select;
            reg_rdata_out[`DCB_BIT_DREAD]    <= diag_read_select;
            reg_rdata_out[`DCB_BIT_FWD]      <= lfsr_forward_select;
            reg_rdata_out[`DCB_BIT_FULL]     <= full_line_select;
            reg_rdata_out[`DCB_ADDR_MSB:`DCB_ADDR_LSB] <= addr_if.q;
         end else if (reg_sel_in == `DCB_IDX_TAG_RB) begin
            reg_rdata_out[`DCB_TAG_W-1:0] <= tag_if[0].q;
         end else if (reg_sel_in == `DCB_IDX_TAG_RB + 5'd1) begin
            reg_rdata_out[`DCB_TAG_W-1:0] <= tag_if[1].q;
         end else if (reg_sel_in == `DCB_IDX_DW_RB) begin
            reg_rdata_out <= dw_if[0].q[63:0];
         end else if (reg_sel_in == `DCB_IDX_DW_RB + 5'd1) begin
            reg_rdata_out <= dw_if[1].q[63:0];
         end else if (reg_sel_in == `DCB_IDX_DW_RB + 5'd2) begin
            reg_rdata_out <= dw_if[2].q[63:0];
         end else if (reg_sel_in == `DCB_IDX_DW_RB + 5'd3) begin
            reg_rdata_out <= dw_if[3].q[63:0];
         end else if (reg_sel_in == `DCB_IDX_DWP_RB) begin
            reg_rdata_out[1:0] <= dw_if[0].q[65:64];
         end else if (reg_sel_in == `DCB_IDX_DWP_RB + 5'd1) begin
            reg_rdata_out[1:0] <= dw_if[1].q[65:64];
         end else if (reg_sel_in == `DCB_IDX_DWP_RB + 5'd2) begin
            reg_rdata_out[1:0] <= dw_if[2].q[65:64];
         end else if (reg_sel_in == `DCB_IDX_DWP_RB + 5'd3) begin
            reg_rdata_out[1:0] <= dw_if[3].q[65:64];
         end
      end
   end
endmodule

//--- testbench/dcbist_engine_checker.sv
// Port-level assertions for the cache self-test engine
`timescale 1ns/1ns
module dcbist_engine_checker (
   input wire logic        clk_in,
   input wire logic        resetn_in,
   input wire logic        reg_wr_in,
   input wire logic        reg_rd_in,
   input wire logic [4:0]  reg_sel_in,
   input wire logic [63:0] reg_wdata_in,
   input wire logic [63:0] reg_rdata_out,
   input wire logic        diag_issue_in,
   input wire logic        busy_out,
   input wire logic        cache_disable_out,
   input wire logic [9:0]  tag_addr_out,
   input wire logic [1:0]  tag_we_out,
   input wire logic [10:0] left_addr_out,
   input wire logic [10:0] right_addr_out,
   input wire logic        data_we_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   logic [15:0] run_len;
   // Length of the current busy run, judged when busy drops
   always_ff @(posedge clk_in) begin
      if (!resetn_in || !busy_out) begin
         run_len <= '0;
      end else begin
         run_len <= run_len + 16'h1;
      end
   end
   property p_cfg_mode;
      reg_wr_in && reg_sel_in == 5'h00 && !busy_out |=>
         cache_disable_out == $past(reg_wdata_in[20]);
   endproperty
   a_cfg_mode: assert property (p_cfg_mode)
      else $error("test mode output does not follow config write");
   property p_off_ignored;
      diag_issue_in && !cache_disable_out && !busy_out |=> !busy_out;
   endproperty
   a_off_ignored: assert property (p_off_ignored)
      else $error("operation started outside test mode");
   property p_issue_busy;
      diag_issue_in && cache_disable_out && !busy_out |=> busy_out;
   endproperty
   a_issue_busy: assert property (p_issue_busy)
      else $error("accepted instruction did not raise busy");
   property p_tag_with_data;
      tag_we_out != 2'b00 |-> data_we_out && busy_out;
   endproperty
   a_tag_with_data: assert property (p_tag_with_data)
      else $error("tag write without data write");
   property p_we_pulse;
      data_we_out |=> !data_we_out;
   endproperty
   a_we_pulse: assert property (p_we_pulse)
      else $error("data write longer than one cycle");
   property p_busy_len;
      $fell(busy_out) |-> run_len == 16'h1 || run_len % 16'h3 == 16'h0;
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("busy run has wrong length");
   property p_addr_share;
      tag_addr_out == left_addr_out[10:1] &&
         left_addr_out[10:1] == right_addr_out[10:1];
   endproperty
   a_addr_share: assert property (p_addr_share)
      else $error("array addresses disagree");
   property p_rb_clear;
      reg_wr_in && reg_sel_in inside {[5'h0a:5'h13]} && !busy_out ##1
         !busy_out ##1 reg_rd_in && reg_sel_in inside {[5'h0a:5'h13]} &&
         !busy_out |=> reg_rdata_out == 64'h0;
   endproperty
   a_rb_clear: assert property (p_rb_clear)
      else $error("read-back not cleared");
   property p_wo_read;
      reg_rd_in && (reg_sel_in inside {[5'h01:5'h09]} ||
         reg_sel_in > 5'h13) |=> reg_rdata_out == 64'h0;
   endproperty
   a_wo_read: assert property (p_wo_read)
      else $error("write-only register readable");
   c_diag: cover property (diag_issue_in && !busy_out ##1 busy_out
      ##1 !busy_out);
   c_step: cover property (busy_out[*3] ##1 !busy_out);
   c_tagw: cover property (tag_we_out == 2'b11);
endmodule
bind dcbist_engine dcbist_engine_checker dcbist_engine_checker_i (
   .clk_in(clk_in), .resetn_in(resetn_in), .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in), .reg_sel_in(reg_sel_in),
   .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
   .diag_issue_in(diag_issue_in), .busy_out(busy_out),
   .cache_disable_out(cache_disable_out), .tag_addr_out(tag_addr_out),
   .tag_we_out(tag_we_out), .left_addr_out(left_addr_out),
   .right_addr_out(right_addr_out), .data_we_out(data_we_out));

//--- testbench/dcbist_array_model.sv
// Behavioural tag, dirty and data arrays facing the engine
`timescale 1ns/1ns
module dcbist_array_model (
   input  wire logic        clk_in,
   input  wire logic [9:0]  tag_addr_in,
   input  wire logic [1:0]  tag_we_in,
   input  wire logic [22:0] tag_wdata_in,
   output logic      [22:0] tag0_out,
   output logic      [22:0] tag1_out,
   input  wire logic [10:0] left_addr_in,
   input  wire logic [10:0] right_addr_in,
   input  wire logic        data_we_in,
   input  wire logic [65:0] lu_in,
   input  wire logic [65:0] ru_in,
   input  wire logic [65:0] ll_in,
   input  wire logic [65:0] rl_in,
   output logic      [65:0] lu_out,
   output logic      [65:0] ru_out,
   output logic      [65:0] ll_out,
   output logic      [65:0] rl_out
);
   logic [22:0] tg0 [1024];
   logic [22:0] tg1 [1024];
   logic [65:0] lu [2048];
   logic [65:0] ru [2048];
   logic [65:0] ll [2048];
   logic [65:0] rl [2048];
   // Cleared so that unwritten entries never feed unknowns to signatures
   initial begin
      for (int i = 0; i < 2048; i++) begin
         lu[i] = '0;
         ru[i] = '0;
         ll[i] = '0;
         rl[i] = '0;
         if (i < 1024) begin
            tg0[i] = '0;
            tg1[i] = '0;
         end
      end
   end
   // Read is combinational from the engine's registered addresses
   assign tag0_out = tg0[tag_addr_in];
   assign tag1_out = tg1[tag_addr_in];
   assign lu_out = lu[left_addr_in];
   assign ll_out = ll[left_addr_in];
   assign ru_out = ru[right_addr_in];
   assign rl_out = rl[right_addr_in];
   always @(posedge clk_in) begin
      if (tag_we_in[0]) tg0[tag_addr_in] <= tag_wdata_in;
      if (tag_we_in[1]) tg1[tag_addr_in] <= tag_wdata_in;
      if (data_we_in) begin
         lu[left_addr_in] <= lu_in;
         ll[left_addr_in] <= ll_in;
         ru[right_addr_in] <= ru_in;
         rl[right_addr_in] <= rl_in;
      end
   end
endmodule

//--- testbench/dcbist_engine_tb.sv
// Self-checking bench for the cache self-test engine
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_total++; \
   $display("wrong value at %0t: got %h want %h", $time, (a), (e)); end end
module dcbist_engine_tb;
   logic clk_in = 0, resetn_in = 0, reg_wr = 0, reg_rd = 0, issue_pl = 0;
   logic [4:0] sel = 0;
   logic [63:0] wd = 0, rdata, q;
   logic busy, dis, dwe;
   logic [1:0] twe;
   logic [9:0] ta;
   logic [10:0] la, ra;
   logic [22:0] tw, t0, t1;
   logic [65:0] luw, ruw, llw, rlw, lur, rur, llr, rlr;
   int err_total = 0, check_count = 0, n;
   localparam logic [11:0] A = 12'h5a3, B = 12'h2b6;
   localparam logic [22:0] TAG = 23'h1234a5;
   logic [63:0] w [4] = '{64'h0123456789abcdef, 64'hfedcba9876543210,
                          64'h00ff00ff00ff00ff, 64'h5555aaaa3333cccc};
   logic [1:0] p [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
   logic [11:0] x;
   always #2 clk_in = ~clk_in;
   dcbist_engine #(.SWEEP_STEPS(7)) dcbist_engine_i (.clk_in(clk_in),
      .resetn_in(resetn_in), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
      .reg_sel_in(sel), .reg_wdata_in(wd), .reg_rdata_out(rdata),
      .diag_issue_in(issue_pl), .busy_out(busy), .cache_disable_out(dis),
      .tag_addr_out(ta), .tag_we_out(twe), .tag_wdata_out(tw),
      .tag_rdata0_in(t0), .tag_rdata1_in(t1), .left_addr_out(la),
      .right_addr_out(ra), .data_we_out(dwe), .left_upper_wdata_out(luw),
      .right_upper_wdata_out(ruw), .left_lower_wdata_out(llw),
      .right_lower_wdata_out(rlw), .left_upper_rdata_in(lur),
      .right_upper_rdata_in(rur), .left_lower_rdata_in(llr),
      .right_lower_rdata_in(rlr));
   dcbist_array_model dcbist_array_model_i (.clk_in(clk_in),
      .tag_addr_in(ta), .tag_we_in(twe), .tag_wdata_in(tw), .tag0_out(t0),
      .tag1_out(t1), .left_addr_in(la), .right_addr_in(ra),
      .data_we_in(dwe), .lu_in(luw), .ru_in(ruw), .ll_in(llw), .rl_in(rlw),
      .lu_out(lur), .ru_out(rur), .ll_out(llr), .rl_out(rlr));
   function automatic logic [11:0] fwd(input logic [11:0] v);
      return {v[10:0], ^(v & 12'h84c)};
   endfunction
   function automatic logic [63:0] cfg(input logic [5:0] b,
                                       input logic [11:0] a);
      return {43'h0, b, a, 3'h0};
   endfunction
   task automatic reg_write(input logic [4:0] s, input logic [63:0] d);
      @(posedge clk_in); #1;
      reg_wr = 1; sel = s; wd = d;
      @(posedge clk_in); #1;
      reg_wr = 0;
   endtask
   task automatic reg_read(input logic [4:0] s, output logic [63:0] d);
      @(posedge clk_in); #1;
      reg_rd = 1; sel = s;
      @(posedge clk_in); #1;
      reg_rd = 0;
      d = rdata;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Counts busy cycles; a hang ends the run
   task automatic issue(output int c);
      @(posedge clk_in); #1;
      issue_pl = 1;
      @(posedge clk_in); #1;
      issue_pl = 0;
      c = 0;
      while (busy === 1'b1 && c < 200) begin
         @(posedge clk_in); #1;
         c++;
      end
      if (c >= 200) begin
         err_total++;
         tally_and_finish();
      end
   endtask
   initial begin
      repeat (2) @(posedge clk_in);
      #1 resetn_in = 1;
      `CHK(dis, 1'b0)
      reg_read(5'h00, q); `CHK(q, 64'h8)
      reg_write(5'h01, {41'h0, TAG});
      for (int i = 0; i < 4; i++) begin
         reg_write(5'(2 + i), w[i]);
         reg_write(5'(6 + i), {62'h0, p[i]});
      end
      // Nothing cacheable stored since reset, so no drain is needed
      reg_write(5'h00, cfg(6'b100000, A)); `CHK(dis, 1'b1)
      issue(n); `CHK(n, 1)
      `CHK(dcbist_array_model_i.tg1[A[11:2]], TAG)
      `CHK(dcbist_array_model_i.tg0[A[11:2]], 23'h0)
      `CHK(dcbist_array_model_i.lu[A[11:1]], {p[0], w[0]})
      `CHK(dcbist_array_model_i.ru[A[11:1]], {p[1], w[1]})
      `CHK(dcbist_array_model_i.rl[A[11:1]], {p[3], w[3]})
      reg_write(5'h00, cfg(6'b100100, A));
      issue(n); `CHK(n, 1)
      reg_read(5'h0a, q); `CHK(q, 64'h0)
      reg_read(5'h0b, q); `CHK(q, {41'h0, TAG})
      reg_read(5'h0c, q); `CHK(q, w[0])
      reg_read(5'h12, q); `CHK(q, {62'h0, p[2]})
      reg_write(5'h11, 64'h0);
      reg_read(5'h0d, q); `CHK(q, 64'h0)
      reg_read(5'h03, q); `CHK(q, 64'h0)
      reg_write(5'h00, cfg(6'b100001, B));
      issue(n);
      x = {B[11:2], ~B[1], 1'b0};
      `CHK(dcbist_array_model_i.ru[x[11:1]], {p[1], w[1]})
      `CHK(dcbist_array_model_i.tg0[B[11:2]], TAG)
      reg_write(5'h00, cfg(6'b111110, A));
      issue(n); `CHK(n, 3)
      reg_read(5'h00, q); `CHK(q[14:3], fwd(A))
      reg_read(5'h0a, q); `CHK(q, {41'h0, TAG})
      reg_read(5'h0b, q);
      `CHK(q, {41'h0, {TAG[21:0], ^(TAG & 23'h400010)} ^ TAG})
      reg_write(5'h00, 64'h194c80);
      issue(n); `CHK(n, 21)
      x = 12'h990;
      for (int i = 0; i < 7; i++) x = fwd(x);
      reg_read(5'h00, q); `CHK(q[14:3], x)
      reg_write(5'h00, cfg(6'b111000, x));
      issue(n);
      x = 12'h990;
      for (int i = 0; i < 6; i++) x = fwd(x);
      reg_read(5'h00, q); `CHK(q[14:3], x)
      reg_write(5'h00, 64'h0); `CHK(dis, 1'b0)
      issue(n); `CHK(n, 0)
      tally_and_finish();
   end
endmodule
